// *** hw/vitcli_top.sv ***
`timescale 1ns/1ps
module vitcli_top (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // host load port, switch settings and phase controls
  input  wire vitcli_pkg::vitcli_load_t host_load,
  input  wire vitcli_pkg::vitcli_cfg_t  cfg,
  input  wire logic                 phase_clear,
  input  wire logic                 burst_enable,
  // video timing pins and remote inputs
  input  wire logic                 hsync_pin,
  input  wire logic                 vsync_pin,
  input  wire logic                 burst_window_pin,
  input  wire logic                 burst_phase_pin,
  input  wire logic [7:0]           remote_pin_n,
  // outputs
  output logic                      vitc_data,
  output logic [1:0]                keyer_select_pair,
  output logic                      vsync_irq,
  output logic                      phase_flag,
  output logic [7:0]                remote_latch,
  output logic                      ctrl_clk_en,
  output logic                      bit_oscillator_testpoint
);
  logic [11:0] pin_s;

  vitcli_sync2 #(.W(12)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({hsync_pin, vsync_pin, burst_window_pin, burst_phase_pin, remote_pin_n}),
    .q    (pin_s)
  );

  typedef struct packed {
    vitcli_pkg::vitcli_state_t st;
    logic [2:0]  bitdiv;
    logic [2:0]  bitph;
    logic [6:0]  bitcnt;
    logic [11:0] delay;
    logic [4:0]  line;
    logic [95:0] shreg;
    logic        vitc_data;
    logic [1:0]  keyer;
    logic        hs_d;
    logic        vs_d;
    logic        win_d;
    logic        irq;
    logic        phase;
    logic [7:0]  remote;
    logic [3:0]  ctrldiv;
    logic        ctrl_en;
    logic        bit_en;
  } vitcli_reg_t;

  vitcli_reg_t r_ff;
  vitcli_reg_t nxt_r;

  logic        hs_rise;
  logic        vs_rise;
  logic        win_rise;
  logic        sel_line;
  logic        guard;
  logic [11:0] delay_load;
  logic [4:0]  line_a;
  logic [4:0]  line_b;

  always_comb
  begin
    hs_rise   = pin_s[11] && !r_ff.hs_d;
    vs_rise   = pin_s[10] && !r_ff.vs_d;
    win_rise  = pin_s[9] && !r_ff.win_d;
    line_a    = vitcli_pkg::FIRST_LINE + {1'b0, cfg.line_a};
    line_b    = vitcli_pkg::FIRST_LINE + {1'b0, cfg.line_b};
    sel_line  = (r_ff.line == line_a) || (r_ff.line == line_b);
    delay_load = (cfg.pal ? vitcli_pkg::DELAY_PAL : vitcli_pkg::DELAY_NTSC)
                 + {5'h00, cfg.delay_trim};
    guard     = (r_ff.bitcnt < 7'(vitcli_pkg::GUARD_BITS))
                || (r_ff.bitcnt >= 7'(vitcli_pkg::BITS_PER_LINE - vitcli_pkg::GUARD_BITS));
    nxt_r         = r_ff;
    nxt_r.hs_d    = pin_s[11];
    nxt_r.vs_d    = pin_s[10];
    nxt_r.win_d   = pin_s[9];
    nxt_r.bit_en  = 1'b0;
    nxt_r.irq     = vs_rise;
    nxt_r.remote  = ~pin_s[7:0];
    // controller clock enable
    nxt_r.ctrl_en = (r_ff.ctrldiv == vitcli_pkg::CTRLDIV_LAST);
    nxt_r.ctrldiv = nxt_r.ctrl_en ? 4'h0 : r_ff.ctrldiv + 4'h1;
    // bit rate enable every eight cycles
    nxt_r.bitdiv  = r_ff.bitdiv + 3'h1;
    if (r_ff.bitdiv == vitcli_pkg::BITDIV_LAST)
      nxt_r.bit_en = 1'b1;
    // line counting from vertical sync
    if (vs_rise)
      nxt_r.line = 5'h00;
    else if (hs_rise && r_ff.line != 5'h1F)
      nxt_r.line = r_ff.line + 5'h01;
    // host loads the pattern whenever load is high while idle
    if (host_load.load && r_ff.st == vitcli_pkg::VITCLI_IDLE)
      nxt_r.shreg = host_load.pattern;
    // burst phase detector, set wins over clear
    if (phase_clear)
      nxt_r.phase = 1'b0;
    if (burst_enable && cfg.colour_framed_setting && win_rise && pin_s[8])
      nxt_r.phase = 1'b1;
    case (r_ff.st)
      vitcli_pkg::VITCLI_IDLE:
      begin
        nxt_r.keyer = 2'b10;
        if (hs_rise && sel_line)
        begin
          nxt_r.delay = delay_load;
          nxt_r.st    = vitcli_pkg::VITCLI_DELAY;
        end
      end
      vitcli_pkg::VITCLI_DELAY:
      begin
        if (r_ff.delay == 12'h000)
        begin
          nxt_r.st     = vitcli_pkg::VITCLI_SHIFT;
          nxt_r.bitcnt = 7'h00;
          nxt_r.bitph  = 3'h0;
          nxt_r.keyer  = 2'b01;
        end
        else
          nxt_r.delay = r_ff.delay - 12'h001;
      end
      vitcli_pkg::VITCLI_SHIFT:
      begin
        // line-aligned bit phase keeps the free divider undisturbed
        nxt_r.bitph = r_ff.bitph + 3'h1;
        if (r_ff.bitph == vitcli_pkg::BITDIV_LAST)
        begin
          nxt_r.vitc_data = guard ? 1'b0 : r_ff.shreg[95];
          nxt_r.shreg     = {r_ff.shreg[94:0], 1'b0};
          nxt_r.bitcnt    = r_ff.bitcnt + 7'h01;
          if (r_ff.bitcnt == 7'(vitcli_pkg::BITS_PER_LINE))
          begin
            nxt_r.st        = vitcli_pkg::VITCLI_IDLE;
            nxt_r.keyer     = 2'b10;
            nxt_r.vitc_data = 1'b0;
          end
        end
      end
      default:
        nxt_r.st = vitcli_pkg::VITCLI_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r_ff       <= '0;
      r_ff.keyer <= 2'b10;
    end
    else
      r_ff <= nxt_r;
  end

  assign vitc_data                = r_ff.vitc_data;
  assign keyer_select_pair        = r_ff.keyer;
  assign vsync_irq                = r_ff.irq;
  assign phase_flag               = r_ff.phase;
  assign remote_latch             = r_ff.remote;
  assign ctrl_clk_en              = r_ff.ctrl_en;
  assign bit_oscillator_testpoint = r_ff.bit_en;
endmodule

// *** shared/vitcli_pkg.sv ***
// How it works
// - oscillator runs at eight times bit rate
// - divider makes bit rate, counts line bits
// - selected line releases delay timer, starts line
// - first bit 10.5 or 11.5 us after sync, plus delay_trim cycles
// - on timeout key on, shift 96 bits
// - serial data re-registered on line-aligned bit phase
// - first and last three bits forced zero
// - key off burst, ends before next sync
// - keyer control is complementary output pair
// - vertical sync raises host interrupt
// - burst window sets phase flag on positive phase
// - controller clock is crystal divided by fifteen
// - remote inputs latched
// - mode jumper selects colour-framed or free-framed
// - two 4-bit fields pick insertion lines
package vitcli_pkg;
  localparam int          BITS_PER_LINE = 96;
  localparam int          GUARD_BITS    = 3;
  localparam int          OSC_PER_BIT   = 8;
  localparam int          CTRL_DIV      = 15;
  localparam real         CLK_MHZ       = 100.0;
  localparam real         DELAY_NTSC_US = 10.5;
  localparam real         DELAY_PAL_US  = 11.5;
  localparam int          DELAY_NTSC_CYC = int'(DELAY_NTSC_US * CLK_MHZ);
  localparam int          DELAY_PAL_CYC  = int'(DELAY_PAL_US * CLK_MHZ);
  localparam logic [11:0] DELAY_NTSC    = DELAY_NTSC_CYC[11:0];
  localparam logic [11:0] DELAY_PAL     = DELAY_PAL_CYC[11:0];
  localparam logic [4:0]  FIRST_LINE    = 5'h06;
  localparam logic [4:0]  CF_LINE_NTSC  = 5'h0A;
  localparam logic [4:0]  CF_LINE_PAL   = 5'h06;
  localparam logic [2:0]  BITDIV_LAST   = 3'h7;
  localparam logic [3:0]  CTRLDIV_LAST  = 4'hE;

  typedef enum logic [1:0] {VITCLI_IDLE, VITCLI_DELAY, VITCLI_SHIFT} vitcli_state_t;

  // host side load port
  typedef struct packed {
    logic                     load;
    logic [BITS_PER_LINE-1:0] pattern;
  } vitcli_load_t;

  // switch and jumper settings
  typedef struct packed {
    logic       pal;
    logic       colour_framed_setting;
    logic [3:0] line_a;
    logic [3:0] line_b;
    logic [6:0] delay_trim;
  } vitcli_cfg_t;
endpackage

// *** hw/vitcli_sync2.sv ***
`timescale 1ns/1ps
module vitcli_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vitcli_s2_t;
  vitcli_s2_t r_ff;
  vitcli_s2_t nxt_r;
  always_comb
  begin
    nxt_r.s1 = d;
    nxt_r.s2 = r_ff.s1;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end
  assign q = r_ff.s2;
endmodule

// *** verification/vitcli_top_sva.sv ***
`timescale 1ns/1ps
module vitcli_top_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // watched ports
  input wire logic       vsync_pin,
  input wire logic       phase_clear,
  input wire logic       vitc_data,
  input wire logic [1:0] keyer_select_pair,
  input wire logic       vsync_irq,
  input wire logic       phase_flag,
  input wire logic       ctrl_clk_en,
  input wire logic       bit_oscillator_testpoint
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic       on;
  logic [9:0] on_cnt_ff;
  assign on = keyer_select_pair == 2'h1;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      on_cnt_ff <= 10'h0;
    else
      on_cnt_ff <= on ? on_cnt_ff + 10'h1 : 10'h0;
  a_key_compl: assert property (on || keyer_select_pair == 2'h2)
    else $error("keyer pair not complementary");
  a_bit_period: assert property (bit_oscillator_testpoint |=>
    !bit_oscillator_testpoint [*7] ##1 bit_oscillator_testpoint) else $error("bit enable period");
  a_ctrl_period: assert property (ctrl_clk_en |-> ##15 ctrl_clk_en)
    else $error("controller enable period");
  a_irq_cause: assert property ($rose(vsync_pin) |-> ##[2:6] vsync_irq)
    else $error("no vsync interrupt");
  a_irq_single: assert property (vsync_irq |=> !vsync_irq)
    else $error("vsync interrupt too long");
  a_key_len: assert property ($fell(on) |-> on_cnt_ff >= 10'h300 && on_cnt_ff <= 10'h308)
    else $error("keyer window length");
  a_guard_lead: assert property (on && on_cnt_ff < 10'h10 |-> !vitc_data)
    else $error("leading guard not zero");
  a_phase_hold: assert property (phase_flag && !phase_clear |=> phase_flag)
    else $error("phase flag dropped");
endmodule
bind vitcli_top vitcli_top_sva u_sva (.clk, .nrst, .vsync_pin, .phase_clear, .vitc_data,
  .keyer_select_pair, .vsync_irq, .phase_flag, .ctrl_clk_en, .bit_oscillator_testpoint);

// *** verification/vitcli_video_model.sv ***
`timescale 1ns/1ps
module vitcli_video_model (
  // clock, reset, phase choice
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic phase,
  // video timing pins
  output logic      hsync_pin,
  output logic      vsync_pin,
  output logic      burst_window_pin,
  output logic      burst_phase_pin
);
  logic [14:0] cnt_ff;
  logic [14:0] pos;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      cnt_ff <= 15'h0;
    else
      cnt_ff <= (cnt_ff == 15'h545F) ? 15'h0 : cnt_ff + 15'h1;
  // nine lines of 2400 cycles per field
  assign pos              = cnt_ff % 15'h960;
  assign hsync_pin        = pos < 15'h32;
  assign vsync_pin        = cnt_ff >= 15'h960 && cnt_ff < 15'h2580;
  assign burst_window_pin = pos >= 15'h3C && pos < 15'h46;
  assign burst_phase_pin  = phase;
endmodule

// *** verification/vitcli_top_tb.sv ***
`timescale 1ns/1ps
module vitcli_top_tb;
  logic clk = 1'b0, nrst = 1'b0, phase_clear = 1'b0, burst_enable = 1'b0, phase = 1'b0;
  vitcli_pkg::vitcli_load_t host_load = '0;
  vitcli_pkg::vitcli_cfg_t  cfg = '0;
  logic [7:0] remote_pin_n = 8'hFF, remote_latch;
  logic [1:0] keyer_select_pair;
  logic hsync_pin, vsync_pin, burst_window_pin, burst_phase_pin, hs_q = 1'b0;
  logic vitc_data, vsync_irq, phase_flag, ctrl_clk_en, bit_oscillator_testpoint;
  logic [95:0] p, e, q[$];
  logic [96:0] cap;
  int err_count = 0, samples_checked = 0, cyc = 0, hs_t = 0, bursts = 0, dly, i, j, k;
  always #5 clk = ~clk;
  vitcli_video_model u_model (.clk, .nrst, .phase, .hsync_pin, .vsync_pin,
    .burst_window_pin, .burst_phase_pin);
  vitcli_top u_dut (.clk, .nrst, .host_load, .cfg, .phase_clear, .burst_enable,
    .hsync_pin, .vsync_pin, .burst_window_pin, .burst_phase_pin, .remote_pin_n,
    .vitc_data, .keyer_select_pair, .vsync_irq, .phase_flag, .remote_latch,
    .ctrl_clk_en, .bit_oscillator_testpoint);
  task close_out;
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] %0t output mismatch", $time);
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    hs_q <= hsync_pin;
    if (hsync_pin && !hs_q) hs_t = cyc;
    if (cyc > 90000)
    begin
      err_count++;
      close_out;
    end
  end
  // monitor: one keyed line per note
  initial forever
  begin
    @(posedge clk iff keyer_select_pair === 2'h1);
    dly = (cfg.pal ? vitcli_pkg::DELAY_PAL_CYC : vitcli_pkg::DELAY_NTSC_CYC) + cfg.delay_trim;
    chk(cyc - hs_t >= dly && cyc - hs_t <= dly + 10);
    e = q.size() > 0 ? q.pop_front() : ~96'h0;
    repeat (4) @(posedge clk);
    for (k = 0; k < 97; k++)
    begin
      cap = {cap[95:0], vitc_data};
      repeat (8) @(posedge clk);
    end
    chk(cap[95:0] === e);
    bursts++;
  end
  initial
  begin
    void'($urandom(1));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    burst_enable <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk iff vsync_irq === 1'b1);
      // frame sync: vsync still high at the three-quarter line point
      repeat (1800) @(posedge clk);
      @(posedge clk iff vsync_pin === 1'b1);
      p = {$urandom, $urandom, $urandom};
      host_load <= '{load: 1'b1, pattern: p};
      q.push_back({3'h0, p[92:3], 3'h0});
      cfg <= '{pal: i == 2, colour_framed_setting: i != 1, line_a: 4'h0, line_b: 4'h0,
               delay_trim: 7'($urandom)};
      remote_pin_n <= 8'($urandom);
      phase <= 1'($urandom);
      phase_clear <= 1'b1;
      @(posedge clk);
      host_load.load <= 1'b0;
      phase_clear <= 1'b0;
      repeat (3) @(posedge clk);
      chk(remote_latch === ~remote_pin_n);
      repeat (2400) @(posedge clk);
      chk(phase_flag === (phase && i != 1));
    end
    for (j = 0; j < 30000 && bursts < 3; j++) @(posedge clk);
    chk(bursts === 3);
    close_out;
  end
endmodule
